// ===== core/cmmc_top.sv
// CAN module mode and status control with its AXI4-Lite register port
`timescale 1ns/100ps
`default_nettype none
module cmmc_top #(parameter int ADDR_W = 8) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_sof_i,          // Start-of-frame of own transmit frame
  input wire logic rx_sof_i,          // Start-of-frame of a receive frame
  input wire logic arb_loss_i,        // Arbitration lost in own frame
  input wire logic bus_off_i,         // Entering bus-off
  input wire logic ifs_first_bit_i,   // First interframe-space bit
  input wire logic ifs_second_rec_i,  // Recessive at second interframe bit
  input wire logic valid_frame_i,     // Valid message frame received
  input wire logic bus_idle_i,        // Bus idle
  output logic [2:0] op_mode_o,       // Operation mode in effect
  output logic [1:0] power_save_o,    // Power-save mode in effect
  output logic err_clear_o,           // Clear error counter and info regs
  output logic retx_on_arb_loss_o,    // Retry after arbitration loss
  output logic ack_drive_en_o         // Engine may drive acknowledge
);
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("cmmc_top: ADDR_W must lie between 8 and 32");
  end

  cmmc_regbus_if #(.ADDR_W(ADDR_W)) rb ();

  cmmc_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid),
    .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid),
    .bready(s_axi_bready), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
    .arready(s_axi_arready), .rdata(s_axi_rdata), .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready), .rb(rb.slv)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic tx_q;          // Transmission in progress
  logic rx_q;          // Reception in progress
  logic error_counter_clear_q;       // Error counter clear request
  logic al_q;          // Retry after arbitration loss
  logic valid_q;       // Valid frame seen
  logic [1:0] ps_q;    // Power-save mode in effect
  logic slp_pend_q;    // Sleep requested, waiting for idle bus
  logic [2:0] opm_q;   // Operation mode in effect
  logic init_pend_q;   // Init requested, waiting for frame gap

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic [7:0] set_b;
  logic [7:0] clr_b;
  logic [2:0] opm_wr;
  logic [1:0] ps_wr;
  logic ps_touch;
  logic opm_take;
  logic enter_init;
  logic [2:0] al_wr;   // Retry control after the pair is applied, bit 0 used

  // Per-bit pair: set-only sets, clear-only clears, else keep
  function automatic logic [2:0] setclr(input logic [2:0] cur,
                                        input logic [2:0] s,
                                        input logic [2:0] c);
    setclr = (s & ~c) | (cur & ~(c & ~s));
  endfunction

  assign ctrl_wr = rb.wr_en && ({rb.wr_addr[7:2], 2'b00} == cmmc_pkg::ADDR_CTRL);
  // Lanes not strobed count as all-zero controls, so they change nothing
  assign set_b = rb.wr_strb[1] ? rb.wr_data[15:8] : 8'h00;
  assign clr_b = rb.wr_strb[0] ? rb.wr_data[7:0] : 8'h00;
  assign opm_wr = setclr(opm_q, set_b[2:0], clr_b[2:0]);
  assign ps_wr = 2'(setclr({1'b0, ps_q}, {1'b0, set_b[4:3]}, {1'b0, clr_b[4:3]}));
  assign ps_touch = |(set_b[4:3] ^ clr_b[4:3]);
  // A function result cannot be bit-selected, so the pair lands in a net first
  assign al_wr = setclr({2'b00, al_q}, {2'b00, set_b[cmmc_pkg::AL_BIT]},
                        {2'b00, clr_b[cmmc_pkg::AL_BIT]});
  // Mode field is locked outside no-power-save and bad codes are dropped
  assign opm_take = ctrl_wr && (ps_q == cmmc_pkg::PS_NONE)
                    && (opm_wr <= cmmc_pkg::OPM_LAST);
  // A pending init waits for a frame gap so no frame is cut short
  assign enter_init = init_pend_q && !opm_take && (ifs_first_bit_i || bus_idle_i);

  assign rb.wr_err = rb.wr_en && !ctrl_wr &&
                     ({rb.wr_addr[7:2], 2'b00} != cmmc_pkg::ADDR_STAT);

  // ----------------------------------------------------------------
  // Operation mode
  // ----------------------------------------------------------------
  // Leaving init is immediate, entering it waits for the frame gap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opm_q <= cmmc_pkg::OPM_INIT;
      init_pend_q <= 1'b0;
    end else if (opm_take) begin
      if (opm_wr == cmmc_pkg::OPM_INIT && opm_q != cmmc_pkg::OPM_INIT) begin
        init_pend_q <= 1'b1;
      end else begin
        opm_q <= opm_wr;
        init_pend_q <= 1'b0;
      end
    end else if (enter_init) begin
      opm_q <= cmmc_pkg::OPM_INIT;
      init_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-save mode
  // ----------------------------------------------------------------
  // Stop is only reached from sleep and only left to sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_q <= cmmc_pkg::PS_NONE;
      slp_pend_q <= 1'b0;
    end else if (ctrl_wr && ps_touch) begin
      unique case (ps_q)
        cmmc_pkg::PS_NONE: begin
          // Sleep pends until the bus is idle; a clear cancels it
          if (ps_wr == cmmc_pkg::PS_SLEEP) begin
            slp_pend_q <= 1'b1;
          end else if (ps_wr == cmmc_pkg::PS_NONE) begin
            slp_pend_q <= 1'b0;
          end
        end
        cmmc_pkg::PS_SLEEP: begin
          if (ps_wr == cmmc_pkg::PS_NONE || ps_wr == cmmc_pkg::PS_STOP) begin
            ps_q <= ps_wr;
          end
        end
        cmmc_pkg::PS_STOP: begin
          if (ps_wr == cmmc_pkg::PS_SLEEP) begin
            ps_q <= ps_wr;
          end
        end
        default: begin
          ps_q <= cmmc_pkg::PS_NONE;
        end
      endcase
    end else if (slp_pend_q && bus_idle_i) begin
      ps_q <= cmmc_pkg::PS_SLEEP;
      slp_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit and receive status
  // ----------------------------------------------------------------
  // A start-of-frame in the clearing cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= 1'b0;
    end else if (tx_sof_i) begin
      tx_q <= 1'b1;
    end else if (bus_off_i || arb_loss_i || ifs_second_rec_i || enter_init) begin
      tx_q <= 1'b0;
    end
  end

  // Reception is busy from its start or after losing arbitration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q <= 1'b0;
    end else if (rx_sof_i || arb_loss_i) begin
      rx_q <= 1'b1;
    end else if (ifs_second_rec_i || enter_init) begin
      rx_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Error counter clear
  // ----------------------------------------------------------------
  // Accepted only while init is in effect, also in the write leaving it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_counter_clear_q <= 1'b0;
    end else if (ctrl_wr && set_b[cmmc_pkg::ERROR_COUNTER_CLEAR_BIT] && clr_b[cmmc_pkg::ERROR_COUNTER_CLEAR_BIT]
                 && opm_q == cmmc_pkg::OPM_INIT) begin
      error_counter_clear_q <= 1'b1;
    end else if (error_counter_clear_q) begin
      error_counter_clear_q <= 1'b0;
    end
  end
  // Clear pulse lasts while the flag stands, one cycle per request
  assign err_clear_o = error_counter_clear_q;

  // ----------------------------------------------------------------
  // Arbitration-loss retry and valid-frame flag
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      al_q <= 1'b0;
    end else if (ctrl_wr) begin
      al_q <= al_wr[0];
    end
  end

  // A frame arriving with the clear keeps the flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_q <= 1'b0;
    end else if (valid_frame_i) begin
      valid_q <= 1'b1;
    end else if (ctrl_wr && clr_b[cmmc_pkg::VALID_BIT]) begin
      valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and read mux
  // ----------------------------------------------------------------
  assign op_mode_o = opm_q;
  assign power_save_o = ps_q;
  // Other modes always retry; single-shot follows the control
  assign retx_on_arb_loss_o = (opm_q != cmmc_pkg::OPM_SINGLE) || al_q;
  assign ack_drive_en_o = (opm_q != cmmc_pkg::OPM_RXONLY) &&
                          (opm_q != cmmc_pkg::OPM_INIT);

  always_comb begin
    rb.rd_data = cmmc_pkg::CTRL_RESET;
    rb.rd_err = 1'b0;
    if ({rb.rd_addr[7:2], 2'b00} == cmmc_pkg::ADDR_CTRL) begin
      rb.rd_data[cmmc_pkg::RX_BIT] = rx_q;
      rb.rd_data[cmmc_pkg::TX_BIT] = tx_q;
      rb.rd_data[cmmc_pkg::ERROR_COUNTER_CLEAR_BIT] = error_counter_clear_q;
      rb.rd_data[cmmc_pkg::AL_BIT] = al_q;
      rb.rd_data[cmmc_pkg::VALID_BIT] = valid_q;
      rb.rd_data[cmmc_pkg::PS_LSB +: 2] = ps_q;
      rb.rd_data[cmmc_pkg::OPM_LSB +: 3] = opm_q;
    end else if ({rb.rd_addr[7:2], 2'b00} == cmmc_pkg::ADDR_STAT) begin
      rb.rd_data[cmmc_pkg::SLP_PEND_BIT] = slp_pend_q;
      rb.rd_data[cmmc_pkg::INIT_PEND_BIT] = init_pend_q;
    end else begin
      rb.rd_err = 1'b1; // Unmapped address
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  tx_set_a: assert property (tx_sof_i |=> tx_q)
    else $error("transmit flag not set at start-of-frame");
  tx_clear_a: assert property ((!tx_sof_i && (bus_off_i || arb_loss_i)) |=> !tx_q)
    else $error("transmit flag not cleared");
  error_counter_clear_gate_a: assert property ((!error_counter_clear_q && opm_q != cmmc_pkg::OPM_INIT) |=> !error_counter_clear_q)
    else $error("counter clear accepted outside init");
  error_counter_clear_auto_a: assert property (error_counter_clear_q |-> err_clear_o ##1 (!error_counter_clear_q || $past(ctrl_wr)))
    else $error("counter clear flag did not drop");
  retx_mode_a: assert property ((opm_q != cmmc_pkg::OPM_SINGLE) |-> retx_on_arb_loss_o)
    else $error("retry suppressed outside single-shot");
  valid_set_a: assert property (valid_frame_i |=> valid_q)
    else $error("valid flag not set after good frame");
  ack_off_a: assert property ((opm_q == cmmc_pkg::OPM_RXONLY) |-> !ack_drive_en_o)
    else $error("acknowledge enabled in receive-only mode");
  ps_legal_a: assert property (ps_q != cmmc_pkg::PS_BAD)
    else $error("prohibited power-save code in effect");
  stop_path_a: assert property ($changed(ps_q) && (ps_q == cmmc_pkg::PS_STOP ||
                                $past(ps_q) == cmmc_pkg::PS_STOP)
                                |-> (ps_q == cmmc_pkg::PS_SLEEP ||
                                     $past(ps_q) == cmmc_pkg::PS_SLEEP))
    else $error("stop mode reached or left without sleep");
  opm_legal_a: assert property (opm_q <= cmmc_pkg::OPM_LAST)
    else $error("prohibited operation mode in effect");
  opm_lock_a: assert property ((ps_q != cmmc_pkg::PS_NONE) |=> $stable(opm_q))
    else $error("operation mode changed during power save");
  al_set_a: assert property ((ctrl_wr && set_b[cmmc_pkg::AL_BIT]
                              && !clr_b[cmmc_pkg::AL_BIT]) |=> al_q)
    else $error("retry control not set by write");
  valid_clr_a: assert property ((ctrl_wr && clr_b[cmmc_pkg::VALID_BIT]
                                 && !valid_frame_i) |=> !valid_q)
    else $error("valid flag not cleared by write");

  sleep_cov: cover property (slp_pend_q ##1 ps_q == cmmc_pkg::PS_SLEEP);
  stop_cov: cover property (ps_q == cmmc_pkg::PS_STOP);
  init_cov: cover property (enter_init);
  error_counter_clear_cov: cover property (error_counter_clear_q ##1 !error_counter_clear_q);
endmodule // cmmc_top
`default_nettype wire

// ===== core/cmmc_pkg.sv
// Shared constants for the CAN module mode control block
package cmmc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Module control register
  localparam logic [7:0] ADDR_STAT = 8'h04; // Pending-request status
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Control register read layout
  // ----------------------------------------------------------------
  localparam int RX_BIT = 9;      // Reception in progress
  localparam int TX_BIT = 8;      // Transmission in progress
  localparam int ERROR_COUNTER_CLEAR_BIT = 7;   // Error counter clear
  localparam int AL_BIT = 6;      // Retry after arbitration loss
  localparam int VALID_BIT = 5;   // Valid frame seen
  localparam int PS_LSB = 3;      // Power-save field, 2 bits
  localparam int OPM_LSB = 0;     // Operation-mode field, 3 bits
  localparam int SET_OFS = 8;     // Set control sits this far above clear
  // Status register layout
  localparam int SLP_PEND_BIT = 0;
  localparam int INIT_PEND_BIT = 1;
  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_NONE = 2'h0;
  localparam logic [1:0] PS_SLEEP = 2'h1;
  localparam logic [1:0] PS_BAD = 2'h2;
  localparam logic [1:0] PS_STOP = 2'h3;
  localparam logic [2:0] OPM_INIT = 3'h0;
  localparam logic [2:0] OPM_NORMAL = 3'h1;
  localparam logic [2:0] OPM_ABT = 3'h2;
  localparam logic [2:0] OPM_RXONLY = 3'h3;
  localparam logic [2:0] OPM_SINGLE = 3'h4;
  localparam logic [2:0] OPM_SELFTEST = 3'h5;
  localparam logic [2:0] OPM_LAST = 3'h5; // Codes above are prohibited
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/cmmc_regbus_if.sv
// Register access strobes between the bus slave and the control logic
`timescale 1ns/100ps
`default_nettype none
interface cmmc_regbus_if #(parameter int ADDR_W = 8);
  logic wr_en;               // One-cycle write strobe
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;              // Unmapped write address
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;      // Combinational read data
  logic rd_err;              // Unmapped read address
  modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface // cmmc_regbus_if
`default_nettype wire

// ===== core/cmmc_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/100ps
`default_nettype none
module cmmc_axil_slave #(parameter int ADDR_W = 8) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  cmmc_regbus_if.slv rb
);
  logic aw_full_q;             // Write address held
  logic w_full_q;              // Write data held
  logic [ADDR_W-1:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Hold off new beats until the response has gone, one write at a time
  assign awready = !aw_full_q && !bvalid;
  assign wready = !w_full_q && !bvalid;
  assign rb.wr_en = aw_full_q && w_full_q;
  assign rb.wr_addr = aw_q;
  assign rb.wr_data = wd_q;
  assign rb.wr_strb = ws_q;

  // Address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
    end else if (rb.wr_en) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
    end
  end

  // Response raised in the cycle after the strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= cmmc_pkg::RESP_OKAY;
    end else if (rb.wr_en) begin
      bvalid <= 1'b1;
      bresp <= rb.wr_err ? cmmc_pkg::RESP_SLVERR : cmmc_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign arready = !rvalid;
  assign rb.rd_addr = araddr;

  // Data sampled at the address handshake, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= cmmc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rb.rd_err ? 32'h0000_0000 : rb.rd_data;
      rresp <= rb.rd_err ? cmmc_pkg::RESP_SLVERR : cmmc_pkg::RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // cmmc_axil_slave
`default_nettype wire

// ===== test/cmmc_can_node.sv
// Far-side stand-in for the CAN protocol engine and bus conditions
`timescale 1ns/100ps
`default_nettype none
module cmmc_can_node (
  input wire logic aclk,
  input wire logic [6:0] ev_i, // One-hot event request from the bench
  input wire logic idle_i,     // Bus idle request from the bench
  output logic [6:0] ev_o,     // Event pulses toward the block
  output logic idle_o          // Bus idle level toward the block
);
  // ----------------------------------------------------------------
  // Event launch
  // ----------------------------------------------------------------
  // Registered so every pulse is a clean single cycle after an edge
  always_ff @(posedge aclk) begin
    ev_o <= ev_i;
    idle_o <= idle_i;
  end
endmodule // cmmc_can_node
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the CAN module mode control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] CT = cmmc_pkg::ADDR_CTRL; // Control word
  localparam logic [7:0] ST = cmmc_pkg::ADDR_STAT; // Pending status
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, idle;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdv; // Write data and last read data
  logic [1:0] rsp;         // Last bus response
  logic [6:0] ev;          // Event requests to the far side
  logic [3:0] strb;        // Write byte strobes
  wire logic [6:0] evp;
  wire logic idlep, awready, wready, bvalid, arready, rvalid, ecl, retx, ack;
  wire logic [1:0] bresp, rresp, ps;
  wire logic [2:0] opm;
  wire logic [31:0] rdata;
  int n_errors, checks_done, n_clr;
  cmmc_top cmmc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_sof_i(evp[0]), .rx_sof_i(evp[1]),
    .arb_loss_i(evp[2]), .bus_off_i(evp[3]), .ifs_first_bit_i(evp[4]),
    .ifs_second_rec_i(evp[5]), .valid_frame_i(evp[6]), .bus_idle_i(idlep),
    .op_mode_o(opm), .power_save_o(ps), .err_clear_o(ecl),
    .retx_on_arb_loss_o(retx), .ack_drive_en_o(ack));
  cmmc_can_node cmmc_can_node_i (.aclk(aclk), .ev_i(ev), .idle_i(idle),
    .ev_o(evp), .idle_o(idlep));
  // Counts the cycles in which the counter clear is driven
  always @(posedge aclk) begin
    if (ecl === 1'b1) n_clr++;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("errors %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Handshakes are judged mid-cycle, acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge aclk);
      ha = awready & awvalid;
      hw = wready & wvalid;
      hb = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        return;
      end
    end
    n_errors++;
    conclude();
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(negedge aclk);
      ha = arready & arvalid;
      hr = rvalid;
      rdv = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) begin
        rready <= 1'b0;
        return;
      end
    end
    n_errors++;
    conclude();
  endtask
  // Reads a register and compares the masked bits
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rdv & m, e);
  endtask
  // One engine event, then time for it to land
  task automatic pulse(input int i);
    @(posedge aclk);
    ev <= 7'h01 << i;
    @(posedge aclk);
    ev <= 7'h00;
    repeat (2) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rc(CT, 32'hffff_ffff, 32'h0);
    rc(ST, 32'hffff_ffff, 32'h0);
    rd(8'h08);
    chk(32'(rsp), 32'(cmmc_pkg::RESP_SLVERR));
    wr(8'h0c, 32'h0);
    chk(32'(rsp), 32'(cmmc_pkg::RESP_SLVERR));
  endtask
  // Walks every legal code, then a prohibited one and back to init
  task automatic t_modes();
    logic [2:0] c;
    for (int i = 1; i <= 5; i++) begin
      c = 3'(i);
      wr(CT, {16'h0, 5'h0, c, 5'h0, ~c});
      chk(32'(opm), 32'(c));
      chk(32'(ack), 32'(c != 3'h3));
      chk(32'(retx), 32'(c != 3'h4));
    end
    wr(CT, 32'h0000_0601);
    rc(CT, 32'h7, 32'h5);
    wr(CT, 32'h0000_0106);
    wr(CT, 32'h0000_0007);
    rc(CT, 32'h7, 32'h1);
    pulse(4);
    rc(CT, 32'h7, 32'h0);
  endtask
  task automatic t_tx();
    wr(CT, 32'h0000_0100);
    pulse(0);
    rc(CT, 32'h300, 32'h100);
    pulse(2);
    rc(CT, 32'h300, 32'h200);
    pulse(0);
    pulse(3);
    rc(CT, 32'h100, 32'h0);
    pulse(0);
    pulse(5);
    rc(CT, 32'h300, 32'h0);
    pulse(0);
    wr(CT, 32'h0000_0007);
    pulse(4);
    rc(CT, 32'h107, 32'h0);
  endtask
  // Init was entered from normal, so a counter clear is safe here
  task automatic t_error_counter_clear();
    int n;
    n = n_clr;
    wr(CT, 32'h0000_8000);
    rc(CT, 32'h80, 32'h0);
    chk(32'(n_clr), 32'(n));
    wr(CT, 32'h0000_8080);
    rc(CT, 32'h80, 32'h0);
    chk(32'(n_clr), 32'(n + 1));
    wr(CT, 32'h0000_8180);
    rc(CT, 32'h87, 32'h1);
    chk(32'(n_clr), 32'(n + 2));
    wr(CT, 32'h0000_8080);
    rc(CT, 32'h80, 32'h0);
    chk(32'(n_clr), 32'(n + 2));
  endtask
  task automatic t_al();
    wr(CT, 32'h0000_0401);
    chk(32'(retx), 32'h0);
    wr(CT, 32'h0000_4000);
    rc(CT, 32'h40, 32'h40);
    chk(32'(retx), 32'h1);
    wr(CT, 32'h0000_4040);
    chk(32'(retx), 32'h1);
    wr(CT, 32'h0000_0040);
    chk(32'(retx), 32'h0);
    wr(CT, 32'h0000_0104);
    chk(32'(retx), 32'h1);
  endtask
  task automatic t_valid();
    pulse(6);
    rc(CT, 32'h20, 32'h20);
    wr(CT, 32'h0000_0000);
    rc(CT, 32'h20, 32'h20);
    // Clear lane not strobed, so the clear control reads as zero
    strb <= 4'h2;
    wr(CT, 32'h0000_0020);
    rc(CT, 32'h20, 32'h20);
    strb <= 4'hf;
    wr(CT, 32'h0000_0020);
    rc(CT, 32'h20, 32'h0);
  endtask
  task automatic t_ps();
    wr(CT, 32'h0000_1800);
    rc(ST, 32'h1, 32'h0);
    wr(CT, 32'h0000_0800);
    rc(CT, 32'h18, 32'h0);
    rc(ST, 32'h1, 32'h1);
    @(posedge aclk);
    idle <= 1'b1;
    // Idle reaches the block one edge late through the far-side model
    repeat (2) @(posedge aclk);
    rc(CT, 32'h18, 32'h08);
    idle <= 1'b0;
    wr(CT, 32'h0000_0201);
    rc(CT, 32'h7, 32'h1);
    wr(CT, 32'h0000_1008);
    rc(CT, 32'h18, 32'h08);
    wr(CT, 32'h0000_1000);
    chk(32'(ps), 32'(cmmc_pkg::PS_STOP));
    wr(CT, 32'h0000_0018);
    rc(CT, 32'h18, 32'h18);
    wr(CT, 32'h0000_0010);
    rc(CT, 32'h18, 32'h08);
    // Release is read back before anything else
    wr(CT, 32'h0000_0008);
    rc(CT, 32'h18, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, idle} = 7'h00;
    {awaddr, araddr, wdata, ev} = '0;
    strb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_tx();
    t_error_counter_clear();
    t_al();
    t_valid();
    t_ps();
    conclude();
  end
endmodule // tb
`default_nettype wire
